// file: bench/mmc_chk.sv
// port checker for the multipoint control mux
`timescale 1ns/10ps
module mmc_chk
(
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // transmit control
  input wire [3:0]  tx_grant,
  input wire [3:0]  tx_active,
  input wire [3:0]  mac_tx_valid,
  input wire [3:0]  cl_tx_ready,
  input wire [3:0]  ctl_tx_ready,
  // receive and timing
  input wire [3:0]  cl_rx_valid,
  input wire        ctl_rx_strobe,
  input wire        rtt_strobe,
  input wire [31:0] rtt_value,
  input wire [31:0] ctl_rx_timestamp,
  input wire [31:0] local_time_counter
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // no leaf reload may land inside the step
  sequence s_quiet;
    !ctl_rx_strobe [*3];
  endsequence
  // a frame stays active over two edges
  sequence s_busy;
    tx_active != 4'h0 ##1 tx_active != 4'h0;
  endsequence
  a_one_grant: assert property ($onehot0(tx_grant))
    else $error("two grants");
  a_one_mac: assert property ($onehot0(mac_tx_valid))
    else $error("two macs");
  a_one_rx: assert property ($onehot0(cl_rx_valid))
    else $error("two rx clients");
  a_ready_grant: assert property (((cl_tx_ready | ctl_tx_ready) & ~tx_grant) == 4'h0)
    else $error("ready without grant");
  a_ctl_first: assert property (ctl_tx_ready != 4'h0 |-> cl_tx_ready == 4'h0)
    else $error("client during control");
  a_grant_hold: assert property (s_busy |-> $stable(tx_grant))
    else $error("grant moved mid frame");
  a_time_step: assert property (s_quiet |=> local_time_counter - $past(local_time_counter) <= 32'h1)
    else $error("time step");
  a_rtt_calc: assert property (rtt_strobe |-> local_time_counter - ctl_rx_timestamp - rtt_value <= 32'h2)
    else $error("rtt value");
endmodule
bind mmc_top mmc_chk mmc_chk_inst (.*);

// file: bench/mmc_mac_model.sv
// mac-side partner: transmit stalls and receive frames
`timescale 1ns/10ps
module mmc_mac_model
(
  // clock
  input wire          aclk,
  // transmit acceptance
  output logic        mac_tx_ready,
  // receive frames
  output logic [3:0]  mac_rx_valid,
  output logic [31:0] mac_rx_data,
  output logic [3:0]  mac_rx_sof,
  output logic [3:0]  mac_rx_eof
);
  initial {mac_tx_ready, mac_rx_valid, mac_rx_data, mac_rx_sof, mac_rx_eof} = 0;
  // random stalls
  always @(posedge aclk)
    mac_tx_ready <= $urandom_range(2) != 0;
  // octet k: length/type, opcode, stamp, else filler
  function automatic logic [7:0] oct(int k, logic [15:0] lt, logic [31:0] ts, logic [7:0] b);
    if (k == 12 || k == 13) return lt[8*(13-k)+:8];
    if (k == 14) return 8'h00;
    if (k == 15) return 8'h02;
    if (k > 15 && k < 20) return ts[8*(19-k)+:8];
    return b + k[7:0];
  endfunction
  // valid frames, octets back to back, idle gap after each; idle lanes noisy
  task automatic send(int j, int n, logic [15:0] lt, logic [31:0] ts, logic [7:0] b);
    logic [31:0] d;
    for (int k = 0; k < n; k++)
    begin
      @(posedge aclk);
      d = $urandom;
      d[8*j+:8] = oct(k, lt, ts, b);
      mac_rx_data <= d;
      mac_rx_valid <= 4'h1 << j;
      mac_rx_sof <= {3'h0, k == 0} << j;
      mac_rx_eof <= {3'h0, k == n - 1} << j;
    end
    @(posedge aclk);
    {mac_rx_valid, mac_rx_sof, mac_rx_eof} <= 12'h000;
    mac_rx_data <= ~d;
    repeat (16) @(posedge aclk);
  endtask
endmodule

// file: bench/tb.sv
// self-checking bench for the multipoint control mux
`timescale 1ns/10ps
module tb;
  logic        aclk = 1'b0;
  logic        aresetn, gate_open, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, mac_tx_sof, mac_tx_eof, mac_tx_ready, cl_rx_sof, cl_rx_eof;
  logic        ctl_rx_strobe, rtt_strobe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ctl_rx_inst;
  logic [3:0]  s_axi_wstrb, cl_tx_valid, cl_tx_eof, ctl_tx_valid, ctl_tx_eof, cl_tx_ready;
  logic [3:0]  ctl_tx_ready, mac_tx_valid, mac_rx_valid, mac_rx_sof, mac_rx_eof, cl_rx_valid;
  logic [3:0]  tx_grant, tx_request_pending, tx_active;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, mac_tx_data, cl_rx_data, b;
  logic [15:0] ctl_rx_opcode;
  logic [31:0] s_axi_wdata, s_axi_rdata, cl_tx_data, ctl_tx_data, mac_rx_data;
  logic [31:0] ctl_rx_timestamp, rtt_value, local_time_counter, t0;
  logic [49:0] tq[$], rq[$], cq[$], aq[$];
  int          n_mismatch = 0;
  int          n_tests = 0;
  mmc_top mmc_top_inst (.*);
  mmc_mac_model mmc_mac_model_inst (.*);
  always #5 aclk = ~aclk;
  function automatic logic [49:0] pop(ref logic [49:0] q[$]);
    if (q.size() == 0) return 'x;
    return q.pop_front();
  endfunction
  task automatic cmp(string s, logic [49:0] e, logic [49:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task summarize;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // used-up wait: mismatch, end run
  task lim(int t, int m);
    if (t >= m)
    begin
      n_mismatch++;
      summarize();
    end
  endtask
  task wt;
    int t;
    for (t = 0; t < 3000 && tq.size() + rq.size() + cq.size() != 0; t++) @(posedge aclk);
    lim(t, 3000);
  endtask
  // one axi4-lite write or read, held until answered
  task automatic axi(bit w, logic [7:0] a, logic [31:0] d, logic [1:0] r);
    int t;
    aq.push_back(w ? r : {r, d});
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    t = 0;
    do
    begin
      @(posedge aclk);
      t++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && t < 99);
    {s_axi_bready, s_axi_rready} <= 2'h0;
    lim(t, 99);
    @(posedge aclk);
  endtask
  // one frame from control (c) or client source i
  task automatic snd(bit c, int i, int n, logic [7:0] b);
    int t;
    for (int k = 0; k < n; k++)
    begin
      if (c) {ctl_tx_valid[i], ctl_tx_eof[i], ctl_tx_data[8*i+:8]} <= {1'b1, k == n - 1, b + k[7:0]};
      else {cl_tx_valid[i], cl_tx_eof[i], cl_tx_data[8*i+:8]} <= {1'b1, k == n - 1, b + k[7:0]};
      t = 0;
      do
      begin
        @(posedge aclk);
        t++;
      end
      while ((c ? ctl_tx_ready[i] : cl_tx_ready[i]) !== 1'b1 && t < 400);
      lim(t, 400);
    end
    if (c) ctl_tx_valid[i] <= 1'b0;
    else cl_tx_valid[i] <= 1'b0;
  endtask
  // results against the oldest note of their kind
  always @(posedge aclk)
  begin
    if ((|mac_tx_valid) === 1'b1 && mac_tx_ready)
      cmp("tx", pop(tq), {mac_tx_valid, mac_tx_sof, mac_tx_eof, mac_tx_data});
    if ((|cl_rx_valid) === 1'b1)
      cmp("rx", pop(rq), {cl_rx_valid, cl_rx_sof, cl_rx_eof, cl_rx_data});
    if (ctl_rx_strobe === 1'b1)
      cmp("ctl", pop(cq), {ctl_rx_inst, ctl_rx_opcode, ctl_rx_timestamp});
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      cmp("bresp", pop(aq), s_axi_bresp);
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      cmp("rdata", pop(aq), {s_axi_rresp, s_axi_rdata});
  end
  initial
  begin
    {aresetn, gate_open, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, cl_tx_valid, cl_tx_eof} = 0;
    {cl_tx_data, ctl_tx_valid, ctl_tx_data, ctl_tx_eof} = 0;
    s_axi_wstrb = 4'hf;
    void'($urandom(32'h5c9e_219e));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi(0, 8'h00, 32'h0000_0000, 2'h0);
    axi(1, 8'h00, 32'h0000_0001, 2'h0);
    axi(0, 8'h00, 32'h0000_0001, 2'h0);
    axi(1, 8'h0c, 32'h0000_0005, 2'h3);
    axi(0, 8'h40, 32'h0000_0000, 2'h3);
    t0 = local_time_counter;
    repeat (160) @(posedge aclk);
    cmp("tick", 32'h0000_0064, local_time_counter - t0);
    $display("test registers done");
    // control and client raised together, control first
    for (int i = 0; i < 4; i++)
    begin
      b = $urandom;
      for (int k = 0; k < 18; k++)
        tq.push_back({4'h1 << i, k == 0 || k == 12, k == 11 || k == 17,
                      (k < 12 ? b : ~b - 8'h0c) + k[7:0]});
      fork
        snd(1'b1, i, 12, b);
        snd(1'b0, i, 6, ~b);
      join
    end
    wt();
    $display("test transmit done");
    for (int j = 0; j < 4; j++)
    begin
      b = $urandom;
      t0 = $urandom;
      for (int k = 0; k < 16; k++)
        rq.push_back({4'h1 << j, k == 0, k == 15, mmc_mac_model_inst.oct(k, 16'h0040, t0, b)});
      cq.push_back({j[1:0], 16'h0002, t0});
      mmc_mac_model_inst.send(j, 16, 16'h0040, t0, b);
      mmc_mac_model_inst.send(j, 21, 16'h8808, t0, b);
    end
    wt();
    $display("test receive done");
    axi(1, 8'h00, 32'h0000_0003, 2'h0);
    gate_open <= 1'b1;
    cq.push_back({2'h0, 16'h0002, 32'hffff_fff0});
    mmc_mac_model_inst.send(0, 21, 16'h8808, 32'hffff_fff0, b);
    wt();
    cmp("load", 1'b1, local_time_counter - 32'hffff_fff0 < 32'h0000_0040);
    axi(0, 8'h04, 32'h0000_0100, 2'h0);
    axi(1, 8'h04, 32'h0000_0100, 2'h0);
    axi(0, 8'h04, 32'h0000_0000, 2'h0);
    repeat (40) @(posedge aclk);
    $display("test leaf done");
    summarize();
  end
endmodule

// file: hdl/mmc_regs.vh
// register map, frame offsets and timing of the control mux
`ifndef MMC_REGS_VH
`define MMC_REGS_VH
// register byte addresses
`define MMC_CTRL_ADDR     8'h00
`define MMC_STAT_ADDR     8'h04
`define MMC_TIME_ADDR     8'h08
`define MMC_RTT_ADDR      8'h0C
// control fields
`define MMC_CTRL_EN_BIT   0
`define MMC_CTRL_LEAF_BIT 1
`define MMC_CTRL_RST      2'h0
// status fields: root drift per instance in [3:0], leaf drift in bit 8
`define MMC_STAT_LEAF_BIT 8
// axi responses
`define MMC_RESP_OKAY     2'h0
`define MMC_RESP_DECERR   2'h3
// frame layout, octet index from first octet
`define MMC_OCT_LT_HI     5'h0C
`define MMC_OCT_LT_LO     5'h0D
`define MMC_OCT_OP_HI     5'h0E
`define MMC_OCT_OP_LO     5'h0F
`define MMC_OCT_TS0       5'h10
`define MMC_OCT_TS3       5'h13
`define MMC_CTL_TYPE      16'h8808
// drift limits in time quanta
`define MMC_ROOT_DRIFT    32'h0000_000C
`define MMC_LEAF_DRIFT    32'h0000_0008
// time quantum and clock period, both in ns
`define MMC_TQ_NS         5'h10
`define MMC_CLK_NS        5'h0A
// parser delay line depth, octets up to the end of length/type
`define MMC_DL_DEPTH      14
`endif

// file: hdl/mmc_rr_arb.v
// round-robin transmit grant arbiter, one grant at most
`timescale 1ns/10ps
module mmc_rr_arb
#(
  parameter N = 4
)
(
  // clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // requests and frame state
  input  wire [N-1:0] pend,
  input  wire         busy,
  input  wire         done,
  // one-hot grant
  output reg  [N-1:0] grant_r
);
  reg     [N-1:0] pick;    // next one-hot grant
  reg     [1:0]   last_r;  // last granted index
  reg     [1:0]   last_nxt;
  reg     [1:0]   idx;
  integer         k;

  // search from last winner; none starves
  always @*
  begin
    pick     = {N{1'b0}};
    last_nxt = last_r;
    idx      = 2'h0;
    for (k = N; k >= 1; k = k - 1)
    begin
      idx = last_r + k[1:0];
      if (pend[idx])
      begin
        pick     = {N{1'b0}};
        pick[idx] = 1'b1;
        last_nxt = idx;
      end
    end
  end

  // grant frozen mid-frame, re-arbitrated after
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      grant_r <= {N{1'b0}};
      last_r  <= 2'h3;
    end
    else if (!busy && (done || !(|(grant_r & pend))))
    begin
      grant_r <= pick;      // [RULE21] [RULE23]
      last_r  <= last_nxt;
    end
  end
endmodule

// file: hdl/mmc_top.v
// multipoint mac control core: parser, mux, transmission control, timing
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "mmc_regs.vh"
// Contract
// [RULE1] only one mac/client pair transmits
// [RULE2] mac j receive goes to client j
// [RULE3] client i request goes to mac i
// [RULE4] one received frame at a time
// [RULE5] mac delivers only valid frames upward
// [RULE6] control frames win over client data
// [RULE7] client path off during control frame
// [RULE8] classify by length/type, route by opcode
// [RULE9] type 0x8808 marks a control frame
// [RULE10] data frames go to paired client
// [RULE11] forward only after transmit grant
// [RULE12] 32-bit time counter, 16 ns tick
// [RULE13] counter wraps, compare by difference msb
// [RULE14] stamp counter at first octet out
// [RULE15] leaf loads counter from received stamp
// [RULE16] root reports rtt = local minus stamp
// [RULE17] root flags rtt change above limit
// [RULE18] root drift limit is 12
// [RULE19] leaf flags stamp offset above limit
// [RULE20] leaf drift limit is 8
// [RULE21] at most one grant asserted
// [RULE22] grant, pending, active per instance
// [RULE23] round-robin, no switch mid-frame
// [RULE24] merge client and control into one request
// [RULE25] root transmit gated by external grant; here only the internal round-robin arbiter grant gates it
// [RULE26] leaf transmit gated by gate function
// [RULE27] leaf uses a single instance
module mmc_top
(
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // client transmit, per instance
  input  wire [3:0]  cl_tx_valid,
  input  wire [31:0] cl_tx_data,
  input  wire [3:0]  cl_tx_eof,
  output reg  [3:0]  cl_tx_ready,
  // control function transmit
  input  wire [3:0]  ctl_tx_valid,
  input  wire [31:0] ctl_tx_data,
  input  wire [3:0]  ctl_tx_eof,
  output reg  [3:0]  ctl_tx_ready,
  // leaf gate window
  input  wire        gate_open,
  // mac transmit, one valid per mac
  output reg  [3:0]  mac_tx_valid,
  output reg  [7:0]  mac_tx_data,
  output reg         mac_tx_sof,
  output reg         mac_tx_eof,
  input  wire        mac_tx_ready,
  // mac receive, contiguous frames
  input  wire [3:0]  mac_rx_valid,
  input  wire [31:0] mac_rx_data,
  input  wire [3:0]  mac_rx_sof,
  input  wire [3:0]  mac_rx_eof,
  // client receive
  output reg  [3:0]  cl_rx_valid,
  output reg  [7:0]  cl_rx_data,
  output reg         cl_rx_sof,
  output reg         cl_rx_eof,
  // control receive indication
  output reg         ctl_rx_strobe,
  output reg  [1:0]  ctl_rx_inst,
  output reg  [15:0] ctl_rx_opcode,
  output reg  [31:0] ctl_rx_timestamp,
  output reg         rtt_strobe,
  output reg  [31:0] rtt_value,
  // transmission control state
  output reg  [3:0]  tx_grant,
  output reg  [3:0]  tx_request_pending,
  output reg  [3:0]  tx_active,
  output reg  [31:0] local_time_counter
);
  // register file
  reg  [1:0]  ctrl_r;      // enable, leaf mode
  reg  [3:0]  rdrift_r;    // sticky root drift per instance
  reg         ldrift_r;    // sticky leaf drift
  reg         aw_held_r;   // write address captured
  reg         w_held_r;    // write data captured
  reg  [7:0]  awaddr_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  wire        wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
  wire        leaf  = ctrl_r[`MMC_CTRL_LEAF_BIT];
  reg  [3:0]  rdrift_set;  // from timing logic
  reg         ldrift_set;

  // write channel: address and data taken in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MMC_RESP_OKAY;
      ctrl_r        <= `MMC_CTRL_RST;
    end
    else
    begin
      s_axi_awready <= ~aw_held_r & ~s_axi_awready;
      s_axi_wready  <= ~w_held_r & ~s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `MMC_RESP_OKAY;
        if (awaddr_r == `MMC_CTRL_ADDR)
        begin
          if (wstrb_r[0])
            ctrl_r <= wdata_r[1:0];
        end
        else if (awaddr_r != `MMC_STAT_ADDR)
          s_axi_bresp <= `MMC_RESP_DECERR;  // unmapped or read-only
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // sticky drift, write one to clear; set wins
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdrift_r <= 4'h0;
      ldrift_r <= 1'b0;
    end
    else
    begin
      rdrift_r <= (rdrift_r & ~((wr_go && awaddr_r == `MMC_STAT_ADDR && wstrb_r[0])
                  ? wdata_r[3:0] : 4'h0)) | rdrift_set;
      ldrift_r <= (ldrift_r & ~(wr_go && awaddr_r == `MMC_STAT_ADDR && wstrb_r[1]
                  && wdata_r[`MMC_STAT_LEAF_BIT])) | ldrift_set;
    end
  end

  // read channel, one outstanding read
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `MMC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `MMC_RESP_OKAY;
        case (s_axi_araddr)
          `MMC_CTRL_ADDR: s_axi_rdata <= {30'h0000_0000, ctrl_r};
          `MMC_STAT_ADDR: s_axi_rdata <= {23'h00_0000, ldrift_r, 4'h0, rdrift_r};
          `MMC_TIME_ADDR: s_axi_rdata <= local_time_counter;
          `MMC_RTT_ADDR:  s_axi_rdata <= rtt_value;
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MMC_RESP_DECERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // local time
  reg  [4:0]  frac_r;      // ns carried toward the next quantum
  reg         ts_load;     // leaf overwrite request
  reg  [31:0] ts_val;

  // fractional 16 ns tick on 10 ns clock, wraps
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      frac_r             <= 5'h00;
      local_time_counter <= 32'h0000_0000;
    end
    else if (ts_load)
    begin
      local_time_counter <= ts_val;          // [RULE15]
      frac_r             <= 5'h00;
    end
    else if (frac_r + `MMC_CLK_NS >= `MMC_TQ_NS)
    begin
      frac_r             <= frac_r + `MMC_CLK_NS - `MMC_TQ_NS;
      local_time_counter <= local_time_counter + 32'h0000_0001;  // [RULE12] [RULE13]
    end
    else
      frac_r <= frac_r + `MMC_CLK_NS;
  end

  // transmit side
  wire [3:0]  grant;
  reg         busy_r;      // frame in flight
  reg         done_r;      // frame finished pulse
  reg         sel_ctl_r;   // current source is a control function
  reg  [1:0]  tinst_r;     // current instance
  reg  [4:0]  toct_r;      // octets sent, saturating
  reg  [31:0] stamp_r;     // time at first octet
  reg  [1:0]  gidx;
  wire        src_v   = sel_ctl_r ? ctl_tx_valid[tinst_r] : cl_tx_valid[tinst_r];
  wire        src_rdy = |(cl_tx_ready | ctl_tx_ready);
  wire        acc     = busy_r & src_v & src_rdy;
  wire [7:0]  cl_b    = cl_tx_data[tinst_r*8 +: 8];
  wire [7:0]  ctl_b   = ctl_tx_data[tinst_r*8 +: 8];
  wire        src_eof = sel_ctl_r ? ctl_tx_eof[tinst_r] : cl_tx_eof[tinst_r];
  wire [31:0] stamp_now = (toct_r == 5'h00) ? local_time_counter : stamp_r;
  reg  [7:0]  ctl_out;     // control octet, stamp inserted
  wire [3:0]  pend_raw = (cl_tx_valid | ctl_tx_valid)
                         & {4{ctrl_r[`MMC_CTRL_EN_BIT]}};
  // leaf: instance 0, inside the gate window only
  wire [3:0]  pend = leaf ? {3'h0, pend_raw[0] & gate_open} : pend_raw;  // [RULE26] [RULE27]

  mmc_rr_arb #(.N(4)) u_arb
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pend    (pend),
    .busy    (busy_r),
    .done    (done_r),
    .grant_r (grant)
  );

  // one-hot grant to index
  always @*
  begin
    case (grant)
      4'h2:    gidx = 2'h1;
      4'h4:    gidx = 2'h2;
      4'h8:    gidx = 2'h3;
      default: gidx = 2'h0;
    endcase
  end

  // stamp octets, big endian, first-octet time
  always @*
  begin
    case (toct_r)
      `MMC_OCT_TS0:          ctl_out = stamp_now[31:24];
      `MMC_OCT_TS0 + 5'h01:  ctl_out = stamp_now[23:16];
      `MMC_OCT_TS0 + 5'h02:  ctl_out = stamp_now[15:8];
      `MMC_OCT_TS3:          ctl_out = stamp_now[7:0];
      default:               ctl_out = ctl_b;
    endcase
  end

  // one-octet output slot; half rate keeps every output registered
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_r       <= 1'b0;
      done_r       <= 1'b0;
      sel_ctl_r    <= 1'b0;
      tinst_r      <= 2'h0;
      toct_r       <= 5'h00;
      stamp_r      <= 32'h0000_0000;
      cl_tx_ready  <= 4'h0;
      ctl_tx_ready <= 4'h0;
      mac_tx_valid <= 4'h0;
      mac_tx_data  <= 8'h00;
      mac_tx_sof   <= 1'b0;
      mac_tx_eof   <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (|mac_tx_valid && mac_tx_ready)
        mac_tx_valid <= 4'h0;
      if (!busy_r && !done_r && |grant && !(|mac_tx_valid))
      begin
        // start only with a grant; control source checked first
        busy_r    <= 1'b1;                             // [RULE11] [RULE25]
        tinst_r   <= gidx;
        toct_r    <= 5'h00;
        sel_ctl_r <= ctl_tx_valid[gidx];               // [RULE6] [RULE24]
      end
      else if (acc)
      begin
        cl_tx_ready  <= 4'h0;
        ctl_tx_ready <= 4'h0;
        mac_tx_valid <= 4'h0;
        mac_tx_valid[tinst_r] <= 1'b1;                 // [RULE3] [RULE1]
        mac_tx_data  <= sel_ctl_r ? ctl_out : cl_b;    // [RULE14]
        mac_tx_sof   <= (toct_r == 5'h00);
        mac_tx_eof   <= src_eof;
        if (toct_r == 5'h00)
          stamp_r <= local_time_counter;               // [RULE14]
        if (toct_r != 5'h1F)
          toct_r <= toct_r + 5'h01;
        if (src_eof)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
      else if (busy_r && !src_rdy && (!(|mac_tx_valid) || mac_tx_ready))
      begin
        // one path opened; clients shut in control frames
        if (sel_ctl_r)
          ctl_tx_ready[tinst_r] <= 1'b1;               // [RULE7]
        else
          cl_tx_ready[tinst_r] <= 1'b1;
      end
    end
  end

  // per-instance grant, pending and active state
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_grant           <= 4'h0;
      tx_request_pending <= 4'h0;
      tx_active          <= 4'h0;
    end
    else
    begin
      tx_grant           <= grant;                     // [RULE22]
      tx_request_pending <= pend;
      tx_active          <= busy_r ? (4'h1 << tinst_r) : 4'h0;
    end
  end

  // receive side
  reg  [12:0] dl_r [0:`MMC_DL_DEPTH-1];  // {inst, valid, sof, eof, data}
  reg         rlock_r;     // a frame is being taken
  reg  [1:0]  rinst_r;     // instance being taken
  reg  [4:0]  roct_r;      // octet index, saturating
  reg  [15:0] lt_r;        // length/type
  reg         is_ctl_r;    // type decision at entry
  reg         out_ctl_r;   // type decision at exit
  reg  [31:0] rts_r;       // received stamp
  reg  [31:0] prev_rtt_r [0:3];
  reg  [3:0]  prev_ok_r;
  reg  [1:0]  ridx;
  reg         r_v;
  integer     i;
  wire [3:0]  rx_allow = leaf ? 4'h1 : 4'hF;
  wire [3:0]  rx_start = mac_rx_valid & mac_rx_sof & rx_allow;
  wire [7:0]  r_b   = mac_rx_data[ridx*8 +: 8];
  wire        r_sof = mac_rx_sof[ridx] & ~rlock_r;
  wire        r_eof = mac_rx_eof[ridx];
  wire [31:0] rtt_new = local_time_counter - rts_r;
  wire [31:0] rtt_dif = rtt_new - prev_rtt_r[rinst_r];
  wire [31:0] rtt_abs = rtt_dif[31] ? (32'h0000_0000 - rtt_dif) : rtt_dif;
  wire [31:0] lf_dif  = rts_r - local_time_counter;
  wire [31:0] lf_abs  = lf_dif[31] ? (32'h0000_0000 - lf_dif) : lf_dif;
  wire [12:0] dl_out  = dl_r[`MMC_DL_DEPTH-1];

  // locked mac, else lowest starting one
  always @*
  begin
    ridx = rinst_r;
    if (!rlock_r)
    begin
      casez (rx_start)
        4'b???1: ridx = 2'h0;
        4'b??10: ridx = 2'h1;
        4'b?100: ridx = 2'h2;
        default: ridx = 2'h3;
      endcase
    end
    r_v = rlock_r ? mac_rx_valid[rinst_r] : |rx_start;  // [RULE4] [RULE5]
  end

  // entry: lock, parse header fields; line shifts every cycle
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rlock_r  <= 1'b0;
      rinst_r  <= 2'h0;
      roct_r   <= 5'h00;
      lt_r     <= 16'h0000;
      is_ctl_r <= 1'b0;
      rts_r    <= 32'h0000_0000;
      ctl_rx_opcode <= 16'h0000;
      for (i = 0; i < `MMC_DL_DEPTH; i = i + 1)
        dl_r[i] <= 13'h0000;
    end
    else
    begin
      dl_r[0] <= {ridx, r_v, r_v & r_sof, r_v & r_eof, r_b};
      for (i = 1; i < `MMC_DL_DEPTH; i = i + 1)
        dl_r[i] <= dl_r[i-1];
      if (r_v)
      begin
        rinst_r <= ridx;
        rlock_r <= ~r_eof;
        roct_r  <= r_sof ? 5'h01 : ((roct_r == 5'h1F) ? roct_r : roct_r + 5'h01);
        if (r_sof)
          is_ctl_r <= 1'b0;
        case (r_sof ? 5'h00 : roct_r)
          `MMC_OCT_LT_HI: lt_r[15:8] <= r_b;
          `MMC_OCT_LT_LO: is_ctl_r <= ({lt_r[15:8], r_b} == `MMC_CTL_TYPE);  // [RULE8] [RULE9]
          `MMC_OCT_OP_HI: ctl_rx_opcode[15:8] <= r_b;
          `MMC_OCT_OP_LO: ctl_rx_opcode[7:0]  <= r_b;
          default:
          begin
            if (roct_r >= `MMC_OCT_TS0 && roct_r <= `MMC_OCT_TS3)
              rts_r <= {rts_r[23:0], r_b};
          end
        endcase
      end
    end
  end

  // exit: data to paired client, control held back
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_ctl_r   <= 1'b0;
      cl_rx_valid <= 4'h0;
      cl_rx_data  <= 8'h00;
      cl_rx_sof   <= 1'b0;
      cl_rx_eof   <= 1'b0;
    end
    else
    begin
      cl_rx_valid <= 4'h0;
      cl_rx_data  <= dl_out[7:0];
      cl_rx_sof   <= dl_out[9];
      cl_rx_eof   <= dl_out[8];
      // decision is ready when octet 0 exits
      if (dl_out[10] && dl_out[9])
        out_ctl_r <= is_ctl_r;
      if (dl_out[10] && !(dl_out[9] ? is_ctl_r : out_ctl_r))
        cl_rx_valid[dl_out[12:11]] <= 1'b1;            // [RULE2] [RULE10]
    end
  end

  // end of stamped control frame: report, rtt, drift
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_rx_strobe    <= 1'b0;
      ctl_rx_inst      <= 2'h0;
      ctl_rx_timestamp <= 32'h0000_0000;
      rtt_strobe       <= 1'b0;
      rtt_value        <= 32'h0000_0000;
      prev_ok_r        <= 4'h0;
      ts_load          <= 1'b0;
      ts_val           <= 32'h0000_0000;
      rdrift_set       <= 4'h0;
      ldrift_set       <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        prev_rtt_r[i] <= 32'h0000_0000;
    end
    else
    begin
      ctl_rx_strobe <= 1'b0;
      rtt_strobe    <= 1'b0;
      ts_load       <= 1'b0;
      rdrift_set    <= 4'h0;
      ldrift_set    <= 1'b0;
      // opcode and stamp go out with the strobe
      if (rlock_r && mac_rx_valid[rinst_r] && r_eof && is_ctl_r && roct_r > `MMC_OCT_TS3)
      begin
        ctl_rx_strobe    <= 1'b1;                      // [RULE8]
        ctl_rx_inst      <= rinst_r;
        ctl_rx_timestamp <= rts_r;
        if (leaf)
        begin
          ts_load    <= 1'b1;                          // [RULE15]
          ts_val     <= rts_r;
          ldrift_set <= (lf_abs > `MMC_LEAF_DRIFT);    // [RULE19] [RULE20] [RULE13]
        end
        else
        begin
          rtt_strobe <= 1'b1;                          // [RULE16]
          rtt_value  <= rtt_new;
          prev_rtt_r[rinst_r] <= rtt_new;
          prev_ok_r[rinst_r]  <= 1'b1;
          if (prev_ok_r[rinst_r] && rtt_abs > `MMC_ROOT_DRIFT)
            rdrift_set[rinst_r] <= 1'b1;               // [RULE17] [RULE18]
        end
      end
    end
  end
endmodule
